/* verilog/epsm_defines.svh */
`ifndef EPSM_DEFINES_SVH
`define EPSM_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EPSM_OFS_MODE_CTRL     12'h000
`define EPSM_OFS_SHUTDOWN_CTRL 12'h004
`define EPSM_OFS_TSEL_LOW      12'h008
`define EPSM_OFS_TSEL_HIGH     12'h00C
`define EPSM_OFS_STEER_CTRL    12'h010
`define EPSM_OFS_RESTART_DB    12'h014
`define EPSM_OFS_DUTY_HIGH     12'h018
`define EPSM_OFS_STATUS        12'h01C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EPSM_RST_MODE_CTRL     8'h00
`define EPSM_RST_SHUTDOWN_CTRL 8'h00
`define EPSM_RST_TSEL          8'h00
`define EPSM_RST_STEER_CTRL    8'h01
`define EPSM_RST_RESTART_DB    8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EPSM_MODE_LSB          0
`define EPSM_DUTY_LOW_LSB      4
`define EPSM_OUTCFG_LSB        6
`define EPSM_STEER_SYNC_BIT    4
`define EPSM_SD_EVENT_BIT      7
`define EPSM_SD_BD_LSB         0
`define EPSM_SD_AC_LSB         2
`define EPSM_RESTART_BIT       7

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define EPSM_MODE_OFF          4'h0
`define EPSM_MODE_CMP_TOGGLE   4'h2
`define EPSM_MODE_CMP_SET      4'h8
`define EPSM_MODE_CMP_CLR      4'h9
`define EPSM_MODE_PWM_HI       2'h3
`define EPSM_OUTCFG_SINGLE     2'h0

`endif

/* verilog/epsm_pkg.sv */
package epsm_pkg;

    // Output configuration decode
    typedef enum logic [1:0]
    {
        EPSM_CFG_SINGLE,
        EPSM_CFG_FULL_FWD,
        EPSM_CFG_HALF,
        EPSM_CFG_FULL_REV
    } epsm_outcfg_t;

    // Unit operating class
    typedef enum logic [2:0]
    {
        EPSM_CLS_OFF,
        EPSM_CLS_CAPTURE,
        EPSM_CLS_COMPARE,
        EPSM_CLS_PWM,
        EPSM_CLS_RESERVED
    } epsm_class_t;

endpackage : epsm_pkg

/* verilog/epsm_pair_shutdown.sv */
`timescale 1ns/1ps
`default_nettype none

// Drives one pin under shutdown: low, high or released.
module epsm_pair_shutdown
(
    // Normal path
    input  wire logic       pin_val,
    input  wire logic       pin_en,
    // Shutdown control
    input  wire logic       shut,
    input  wire logic [1:0] state,
    // Result
    output logic            out_val,
    output logic            out_en
);

    // ----------------------------------------------------------------
    // Shutdown override
    // ----------------------------------------------------------------
    // Only driven pins are overridden
    always_comb
    begin
        out_val = pin_val;
        out_en  = pin_en;
        if (shut && pin_en)
        begin
            out_val = state[0];
            out_en  = ~state[1];
        end
    end

endmodule : epsm_pair_shutdown

`default_nettype wire

/* verilog/epsm_capture_div.sv */
`timescale 1ns/1ps
`default_nettype none

// Capture edge qualifier
module epsm_capture_div
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // Control
    input  wire logic       enable,
    input  wire logic [1:0] sel,
    input  wire logic       pin_in,
    // Event
    output logic            capture
);

    typedef struct packed
    {
        logic       prev;
        logic [3:0] cnt;
    } epsm_cap_state_t;

    epsm_cap_state_t s_reg;
    epsm_cap_state_t s_next;
    logic            rise;
    logic            fall;

    // ----------------------------------------------------------------
    // Edge detection and prescale
    // ----------------------------------------------------------------
    always_comb
    begin
        s_next      = s_reg;
        rise        = pin_in & ~s_reg.prev;
        fall        = ~pin_in & s_reg.prev;
        capture     = 1'b0;
        s_next.prev = pin_in;
        if (!enable)
        begin
            s_next.cnt = 4'h0;
        end
        else
        begin
            unique case (sel)
                2'h0: capture = fall;
                2'h1: capture = rise;
                2'h2: capture = rise && (s_reg.cnt[1:0] == 2'h3);
                2'h3: capture = rise && (s_reg.cnt == 4'hF);
            endcase
            if (rise)
            begin
                s_next.cnt = s_reg.cnt + 4'h1;
            end
        end
    end

    // Prescaler state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg <= '0;
        end
        else if (ce)
        begin
            s_reg <= s_next;
        end
    end

endmodule : epsm_capture_div

`default_nettype wire

/* verilog/epsm_unit.sv */
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "epsm_defines.svh"

// ----------------------------------------------------------------
// Enhanced PWM mode decode and output steering
// ----------------------------------------------------------------
module epsm_unit
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Period timers
    input  wire logic [2:0]  timer_period_match,
    input  wire logic [23:0] timer_count,
    input  wire logic        compare_match,
    // Capture input and shutdown sources
    input  wire logic        capture_pin,
    input  wire logic        shutdown_level,
    // Pins
    output logic      [3:0]  pin_out,
    output logic      [3:0]  pin_oe,
    // Events
    output logic             unit_interrupt_flag,
    output logic             capture_event
);

    // Whole unit state
    typedef struct packed
    {
        logic [7:0]  mode_ctrl;
        logic [7:0]  sd_ctrl;
        logic [7:0]  tsel_low;
        logic [1:0]  tsel_high;
        logic [4:0]  steer_ctrl;
        logic [3:0]  steer_active;
        logic [7:0]  restart_db;
        logic [7:0]  duty_high;
        logic        cmp_out;
        logic        pwm_raw;
        logic [3:0]  pin_out;
        logic [3:0]  pin_oe;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        cap;
    } epsm_state_t;

    epsm_state_t           s_reg;
    epsm_state_t           s_next;
    logic                  access;
    logic                  cap_hit;
    logic                  period_hit;
    logic [7:0]            tmr_cnt;
    logic [9:0]            duty;
    logic [3:0]            mode;
    logic                  steer_on;
    logic                  shut;
    logic [3:0]            mod_val;
    logic [3:0]            mod_en;
    logic [3:0]            sd_val;
    logic [3:0]            sd_en;
    epsm_pkg::epsm_outcfg_t cfg;

    // Mode class decode
    function automatic epsm_pkg::epsm_class_t mode_class(input logic [3:0] m);
        begin
            if (m == `EPSM_MODE_OFF)
                mode_class = epsm_pkg::EPSM_CLS_OFF;
            else if (m == 4'h1 || m == 4'h3)
                mode_class = epsm_pkg::EPSM_CLS_RESERVED;
            else if (m[3:2] == 2'h1)
                mode_class = epsm_pkg::EPSM_CLS_CAPTURE;
            else if (m[3:2] == `EPSM_MODE_PWM_HI)
                mode_class = epsm_pkg::EPSM_CLS_PWM;
            else
                mode_class = epsm_pkg::EPSM_CLS_COMPARE;
        end
    endfunction : mode_class

    // ----------------------------------------------------------------
    // Capture prescaler and shutdown override per pin
    // ----------------------------------------------------------------
    epsm_capture_div u_cap
    (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .enable  (mode_class(mode) == epsm_pkg::EPSM_CLS_CAPTURE),
        .sel     (mode[1:0]),
        .pin_in  (capture_pin),
        .capture (cap_hit)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_pin
            epsm_pair_shutdown u_sd
            (
                .pin_val (mod_val[gi]),
                .pin_en  (mod_en[gi]),
                .shut    (shut),
                .state   (gi[0] ? s_reg.sd_ctrl[`EPSM_SD_BD_LSB +: 2] : s_reg.sd_ctrl[`EPSM_SD_AC_LSB +: 2]),
                .out_val (sd_val[gi]),
                .out_en  (sd_en[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Time base and pin waveform
    // ----------------------------------------------------------------
    always_comb
    begin
        mode     = s_reg.mode_ctrl[`EPSM_MODE_LSB +: 4];
        cfg      = epsm_pkg::epsm_outcfg_t'(s_reg.mode_ctrl[`EPSM_OUTCFG_LSB +: 2]);
        duty     = {s_reg.duty_high, s_reg.mode_ctrl[`EPSM_DUTY_LOW_LSB +: 2]};
        steer_on = (mode[3:2] == `EPSM_MODE_PWM_HI) && (cfg == epsm_pkg::EPSM_CFG_SINGLE);
        shut     = s_reg.sd_ctrl[`EPSM_SD_EVENT_BIT] | shutdown_level;
        // Reserved 11 uses the first timer
        unique case (s_reg.tsel_low[1:0])
            2'h1:    begin tmr_cnt = timer_count[15:8];  period_hit = timer_period_match[1]; end
            2'h2:    begin tmr_cnt = timer_count[23:16]; period_hit = timer_period_match[2]; end
            default: begin tmr_cnt = timer_count[7:0];   period_hit = timer_period_match[0]; end
        endcase
        mod_val = 4'h0;
        mod_en  = 4'h0;
        if (mode_class(mode) == epsm_pkg::EPSM_CLS_PWM)
        begin
            if (steer_on)
            begin
                // Pair polarity on every steered pin
                mod_val = {s_reg.pwm_raw ^ mode[0], s_reg.pwm_raw ^ mode[1],
                           s_reg.pwm_raw ^ mode[0], s_reg.pwm_raw ^ mode[1]};
                mod_en  = s_reg.steer_active;
            end
            else
            begin
                unique case (cfg)
                    epsm_pkg::EPSM_CFG_FULL_FWD:
                    begin
                        mod_val = {s_reg.pwm_raw ^ mode[0], mode[1], mode[0], ~mode[1]};
                        mod_en  = 4'hF;
                    end
                    epsm_pkg::EPSM_CFG_HALF:
                    begin
                        mod_val = {2'h0, ~s_reg.pwm_raw ^ mode[0], s_reg.pwm_raw ^ mode[1]};
                        mod_en  = 4'h3;
                    end
                    epsm_pkg::EPSM_CFG_FULL_REV:
                    begin
                        mod_val = {mode[0], ~mode[1], s_reg.pwm_raw ^ mode[0], mode[1]};
                        mod_en  = 4'hF;
                    end
                    default:
                    begin
                        mod_val = 4'h0;
                        mod_en  = 4'h0;
                    end
                endcase
            end
        end
        else if (mode_class(mode) == epsm_pkg::EPSM_CLS_COMPARE)
        begin
            mod_val = {3'h0, s_reg.cmp_out};
            mod_en  = 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_next         = s_reg;
        access         = psel && penable && !s_reg.pready;
        s_next.pready  = access;
        s_next.pslverr = 1'b0;
        s_next.irq     = 1'b0;
        s_next.cap     = cap_hit;

        // PWM high while count below duty
        s_next.pwm_raw = ({tmr_cnt, 2'h0} < duty);

        // Synchronised steering moves at period match
        if (period_hit && s_reg.steer_ctrl[`EPSM_STEER_SYNC_BIT])
        begin
            s_next.steer_active = s_reg.steer_ctrl[3:0];
        end

        // Compare actions
        if (compare_match)
        begin
            unique case (mode)
                `EPSM_MODE_CMP_TOGGLE: s_next.cmp_out = ~s_reg.cmp_out;
                `EPSM_MODE_CMP_SET:    begin s_next.cmp_out = 1'b1; s_next.irq = 1'b1; end
                `EPSM_MODE_CMP_CLR:    begin s_next.cmp_out = 1'b0; s_next.irq = 1'b1; end
                default:               s_next.cmp_out = s_reg.cmp_out;
            endcase
        end

        // Auto restart clears event once level is gone
        if (s_reg.restart_db[`EPSM_RESTART_BIT] && !shutdown_level)
        begin
            s_next.sd_ctrl[`EPSM_SD_EVENT_BIT] = 1'b0;
        end

        // Off clears the compare output and PWM level; a mode write below still lands
        if (mode == `EPSM_MODE_OFF)
        begin
            s_next.cmp_out = 1'b0;
            s_next.pwm_raw = 1'b0;
        end

        // Register access
        if (access && pwrite)
        begin
            unique case (paddr)
                `EPSM_OFS_MODE_CTRL:
                begin
                    s_next.mode_ctrl = pwdata[7:0];
                    // Set and clear compare codes preset the opposite pin level; toggle does not
                    if (pwdata[3:0] == `EPSM_MODE_CMP_SET)
                        s_next.cmp_out = 1'b0;
                    else if (pwdata[3:0] == `EPSM_MODE_CMP_CLR)
                        s_next.cmp_out = 1'b1;
                end
                `EPSM_OFS_SHUTDOWN_CTRL:
                begin
                    s_next.sd_ctrl[6:0] = pwdata[6:0];
                    // Event bit locked while level persists
                    if (!shutdown_level)
                        s_next.sd_ctrl[`EPSM_SD_EVENT_BIT] = pwdata[7];
                end
                `EPSM_OFS_TSEL_LOW:   s_next.tsel_low   = pwdata[7:0];
                `EPSM_OFS_TSEL_HIGH:  s_next.tsel_high  = pwdata[1:0];
                `EPSM_OFS_STEER_CTRL:
                begin
                    s_next.steer_ctrl = pwdata[4:0];
                    if (!pwdata[`EPSM_STEER_SYNC_BIT])
                        s_next.steer_active = pwdata[3:0];
                end
                `EPSM_OFS_RESTART_DB: s_next.restart_db = pwdata[7:0];
                `EPSM_OFS_DUTY_HIGH:  s_next.duty_high  = pwdata[7:0];
                `EPSM_OFS_STATUS:     s_next.pslverr    = 1'b1;
                default:              s_next.pslverr    = 1'b1;
            endcase
        end
        else if (access)
        begin
            unique case (paddr)
                `EPSM_OFS_MODE_CTRL:     s_next.prdata = {24'h0, s_reg.mode_ctrl};
                `EPSM_OFS_SHUTDOWN_CTRL: s_next.prdata = {24'h0, s_reg.sd_ctrl};
                `EPSM_OFS_TSEL_LOW:      s_next.prdata = {24'h0, s_reg.tsel_low};
                `EPSM_OFS_TSEL_HIGH:     s_next.prdata = {30'h0, s_reg.tsel_high};
                `EPSM_OFS_STEER_CTRL:    s_next.prdata = {27'h0, s_reg.steer_ctrl};
                `EPSM_OFS_RESTART_DB:    s_next.prdata = {24'h0, s_reg.restart_db};
                `EPSM_OFS_DUTY_HIGH:     s_next.prdata = {24'h0, s_reg.duty_high};
                `EPSM_OFS_STATUS:        s_next.prdata = {23'h0, steer_on, s_reg.steer_active, s_reg.cmp_out,
                                                          mode_class(mode)};
                default:
                begin
                    s_next.prdata  = 32'h0000_0000;
                    s_next.pslverr = 1'b1;
                end
            endcase
        end

        // Level shutdown sets event bit; set wins
        if (shutdown_level)
        begin
            s_next.sd_ctrl[`EPSM_SD_EVENT_BIT] = 1'b1;
        end

        // Registered pins
        s_next.pin_out = sd_val;
        s_next.pin_oe  = sd_en;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg              <= '0;
            s_reg.steer_ctrl   <= 5'(`EPSM_RST_STEER_CTRL);
            s_reg.steer_active <= 4'h1;
        end
        else if (ce)
        begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flip-flops
    assign prdata              = s_reg.prdata;
    assign pready              = s_reg.pready;
    assign pslverr             = s_reg.pslverr;
    assign pin_out             = s_reg.pin_out;
    assign pin_oe              = s_reg.pin_oe;
    assign unit_interrupt_flag = s_reg.irq;
    assign capture_event       = s_reg.cap;

endmodule : epsm_unit

`default_nettype wire

/* verif/epsm_unit_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "epsm_defines.svh"
// ----------------------------------------------------------------
// Port checker for the steering unit
// ----------------------------------------------------------------
module epsm_unit_monitor
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Events and pins
    input wire logic        compare_match,
    input wire logic        unit_interrupt_flag,
    input wire logic [3:0]  pin_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [7:0] mode_sh;
    logic [7:0] mode_old;
    logic       steady;

    // Mode shadow; checks wait until it holds
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_sh  <= 8'h00;
            mode_old <= 8'h00;
        end
        else
        begin
            mode_old <= mode_sh;
            if (psel && penable && pready && pwrite && paddr == `EPSM_OFS_MODE_CTRL)
                mode_sh <= pwdata[7:0];
        end
    end
    assign steady = (mode_sh == mode_old);

    a_ready_after_access: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_refuse_unmapped: assert property (pready && paddr > `EPSM_OFS_STATUS |-> pslverr)
        else $error("unmapped access accepted");
    a_refuse_status_write: assert property (pready && pwrite && paddr == `EPSM_OFS_STATUS |-> pslverr)
        else $error("status write accepted");
    a_off_pins_idle: assert property (steady && mode_sh[3:0] == 4'h0 |-> pin_oe == 4'h0)
        else $error("pins driven while off");
    a_nonpwm_pin_a: assert property (steady && mode_sh[3:2] != 2'h3 |-> pin_oe[3:1] == 3'h0)
        else $error("port pin driven outside pwm");
    a_flag_on_match: assert property (steady && mode_sh[3:1] == 3'h4 && $past(compare_match)
        && !$past(compare_match, 2) |-> unit_interrupt_flag)
        else $error("flag missing on match");
    a_flag_cause: assert property (unit_interrupt_flag |-> $past(compare_match))
        else $error("flag without match");
endmodule : epsm_unit_monitor

bind epsm_unit epsm_unit_monitor mon_u
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .compare_match(compare_match),
    .unit_interrupt_flag(unit_interrupt_flag), .pin_oe(pin_oe)
);
`default_nettype wire

/* verif/epsm_bridge_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Bridge switch drivers on the four pins
// ----------------------------------------------------------------
module epsm_bridge_model
(
    // Pins from the unit
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    // Port direction latches, low = output
    input  wire logic [3:0] pin_dir_n,
    // Gate level seen by each switch
    output logic      [3:0] gate
);
    // Pull-downs keep a switch off whenever its pin floats
    always_comb gate = ~pin_dir_n & pin_oe & pin_out;
endmodule : epsm_bridge_model
`default_nettype wire

/* verif/epsm_unit_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "epsm_defines.svh"
// ----------------------------------------------------------------
// Register-level test of the steering unit
// ----------------------------------------------------------------
module epsm_unit_test;
    logic        pclk     = 1'b0;
    logic        presetn  = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0;
    logic [2:0]  tmatch   = 3'h0;
    logic [7:0]  cnt      = 8'h00;
    logic        cmatch   = 1'b0;
    logic        cap_pin  = 1'b0;
    logic        shut_lvl = 1'b0;
    logic [3:0]  dir_n    = 4'hF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe;
    logic [3:0]  gate;
    logic [7:0]  pins;
    logic        irq_flag;
    logic        cap_evt;
    logic [31:0] rdat;
    logic        err;
    int          miscompares = 0;
    int          compares    = 0;
    int          cycles      = 0;
    int          events      = 0;
    logic [3:0]  mode_tab [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hC};
    logic [2:0]  cls_tab  [7] = '{3'h0, 3'h4, 3'h2, 3'h4, 3'h1, 3'h2, 3'h3};
    logic [7:0]  sd_tab   [4] = '{8'h04, 8'h01, 8'h08, 8'h02};
    logic [7:0]  sd_exp   [4] = '{8'h31, 8'h32, 8'h20, 8'h10};
    logic [3:0]  cmp_tab  [3] = '{4'h8, 4'h9, 4'h2};
    int          cap_exp  [4] = '{16, 16, 4, 1};

    always #2 pclk = ~pclk;

    epsm_unit dut_u
    (
        .pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_period_match(tmatch), .timer_count({cnt, cnt, cnt}), .compare_match(cmatch),
        .capture_pin(cap_pin), .shutdown_level(shut_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
        .unit_interrupt_flag(irq_flag), .capture_event(cap_evt)
    );
    epsm_bridge_model drv_u (.pin_out(pin_out), .pin_oe(pin_oe), .pin_dir_n(dir_n), .gate(gate));
    assign pins = {pin_oe, pin_out & pin_oe};

    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] exp, got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk($sformatf("read %h", a), exp, rdat);
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    task automatic set_count(input logic [7:0] c);
        @(posedge pclk);
        cnt <= c;
        settle(3);
    endtask : set_count

    task automatic tick(input logic [2:0] t);
        @(posedge pclk);
        tmatch <= t;
        @(posedge pclk);
        tmatch <= 3'h0;
        settle(1);
    endtask : tick

    // Pin levels for pwm level p under pair polarity m
    function automatic logic [31:0] pol(input logic p, input logic [1:0] m);
        return {28'h0, p ^ m[0], p ^ m[1], p ^ m[0], p ^ m[1]};
    endfunction : pol

    // Timeout and capture tally
    always @(posedge pclk)
    begin
        cycles++;
        events += int'(cap_evt === 1'b1);
        if (cycles == 20000)
        begin
            miscompares++;
            close_out();
        end
    end

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`EPSM_OFS_MODE_CTRL, 32'h0);
        rd(`EPSM_OFS_STEER_CTRL, 32'h1);
        rd(`EPSM_OFS_TSEL_LOW, 32'h0);
        apb(1'b1, `EPSM_OFS_STATUS, 32'hFF);
        chk("status wr", 32'h1, 32'(err));
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped refused", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rdat);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, `EPSM_OFS_MODE_CTRL, 32'(mode_tab[i]));
            apb(1'b0, `EPSM_OFS_STATUS, 32'h0);
            chk("mode class", 32'(cls_tab[i]), 32'(rdat[2:0]));
        end
        // Steered single output, duty 0x203
        apb(1'b1, `EPSM_OFS_DUTY_HIGH, 32'h80);
        apb(1'b1, `EPSM_OFS_STEER_CTRL, 32'h0F);
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, `EPSM_OFS_MODE_CTRL, 32'h3C | m);
            apb(1'b0, `EPSM_OFS_STATUS, 32'h0);
            chk("steer mode", 32'h1, 32'(rdat[8]));
            set_count(8'h80);
            chk("pwm high", pol(1'b1, m[1:0]), 32'(pin_out));
            set_count(8'h81);
            chk("pwm low", pol(1'b0, m[1:0]), 32'(pin_out));
        end
        tick(3'h1);
        tick(3'h1);
        dir_n <= 4'h0;
        settle(1);
        chk("gate", pol(1'b0, 2'h3), 32'(gate));
        // Full bridge, pwm high
        apb(1'b1, `EPSM_OFS_MODE_CTRL, 32'h4C);
        set_count(8'h10);
        chk("fwd pins", 32'h9, 32'(pin_out));
        apb(1'b1, `EPSM_OFS_MODE_CTRL, 32'hCC);
        settle(2);
        chk("rev pins", 32'h6, 32'(pin_out));
        apb(1'b1, `EPSM_OFS_MODE_CTRL, 32'h0C);
        for (int s = 1; s < 16; s++)
        begin
            apb(1'b1, `EPSM_OFS_STEER_CTRL, 32'(s));
            settle(1);
            chk("steer now", 32'(s), 32'(pin_oe));
        end
        // Sync steering on selected timer
        apb(1'b1, `EPSM_OFS_TSEL_LOW, 32'h1);
        apb(1'b1, `EPSM_OFS_STEER_CTRL, 32'h11);
        tick(3'h1);
        chk("steer held", 32'hF, 32'(pin_oe));
        tick(3'h2);
        chk("steer moved", 32'h1, 32'(pin_oe));
        apb(1'b1, `EPSM_OFS_TSEL_LOW, 32'h2);
        apb(1'b1, `EPSM_OFS_STEER_CTRL, 32'h1C);
        tick(3'h2);
        chk("steer held", 32'h1, 32'(pin_oe));
        tick(3'h4);
        chk("steer moved", 32'hC, 32'(pin_oe));
        apb(1'b1, `EPSM_OFS_TSEL_LOW, 32'h0);
        apb(1'b1, `EPSM_OFS_STEER_CTRL, 32'h03);
        // Shutdown hits steered A, B only
        @(posedge pclk);
        shut_lvl <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, `EPSM_OFS_SHUTDOWN_CTRL, 32'(sd_tab[i]));
            settle(2);
            chk("sd pins", 32'(sd_exp[i]), 32'(pins));
        end
        @(posedge pclk);
        shut_lvl <= 1'b0;
        settle(3);
        chk("sd kept", 32'h10, 32'(pins));
        apb(1'b1, `EPSM_OFS_SHUTDOWN_CTRL, 32'h0);
        tick(3'h1);
        chk("restart", 32'h33, 32'(pins));
        // Compare: start, flag, after match
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, `EPSM_OFS_MODE_CTRL, 32'h0);
            apb(1'b1, `EPSM_OFS_MODE_CTRL, 32'(cmp_tab[i]));
            settle(1);
            chk("cmp start", 32'(i == 1), 32'(pin_out[0]));
            chk("cmp oe", 32'h1, 32'(pin_oe));
            @(posedge pclk);
            cmatch <= 1'b1;
            @(posedge pclk);
            cmatch <= 1'b0;
            @(negedge pclk);
            chk("cmp flag", 32'(i < 2), 32'(irq_flag));
            settle(1);
            chk("cmp after", 32'(i != 1), 32'(pin_out[0]));
        end
        // Capture edges, config ignored
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, `EPSM_OFS_MODE_CTRL, 32'hC4 | k);
            settle(1);
            events = 0;
            repeat (16)
            begin
                @(posedge pclk);
                cap_pin <= 1'b1;
                repeat (3) @(posedge pclk);
                cap_pin <= 1'b0;
                repeat (3) @(posedge pclk);
            end
            settle(4);
            chk("cap count", 32'(cap_exp[k]), 32'(events));
        end
        apb(1'b1, `EPSM_OFS_MODE_CTRL, 32'h0);
        settle(2);
        chk("off pins", 32'h0, 32'(pin_oe));
        close_out();
    end
endmodule : epsm_unit_test
`default_nettype wire
